// ==== dv/xdma_mem_model.sv ====
// Slave memory and peripheral data source answering both master ports.
`timescale 1ns/1ps
module xdma_mem_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        slow,
  input  wire logic        err_a,
  input  wire logic        err_b,
  input  wire logic        a_req,
  input  wire logic [31:0] a_addr,
  output logic             a_ready,
  output logic [31:0]      a_rdata,
  output logic             a_err,
  input  wire logic        b_req,
  input  wire logic [31:0] b_addr,
  input  wire logic [1:0]  b_size,
  input  wire logic [31:0] b_wdata,
  output logic             b_ready,
  output logic             b_err
);
  logic [31:0] mem [0:255];
  logic [7:0]  lfsr_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) lfsr_reg <= 8'h5a;
    else lfsr_reg <= {lfsr_reg[6:0], ^(lfsr_reg & 8'hb8)};
  end
  // Slow mode: shared slaves insert random wait states
  assign a_ready = a_req && (!slow || lfsr_reg[0]);
  assign b_ready = b_req && (!slow || lfsr_reg[3]);
  assign a_err   = a_ready && err_a;
  assign b_err   = b_ready && err_b;
  // Unanswered bus shows junk so stale data is never mistaken for valid
  // Narrow items travel right-justified on both data buses
  assign a_rdata = a_ready ? mem[a_addr[9:2]] >> {a_addr[1:0], 3'h0} :
                   ~mem[a_addr[9:2]] ^ {4{lfsr_reg}};
  always @(posedge clk) begin
    if (b_req && b_ready && !err_b) begin
      for (int k = 0; k < 4; k++) begin
        if (k < (1 << b_size)) begin
          mem[b_addr[9:2]][8*(b_addr[1:0]+k) +: 8] <= b_wdata[8*k +: 8];
        end
      end
    end
  end
endmodule // xdma_mem_model

// ==== dv/xdma_stream_ctrl_bench.sv ====
// Self-checking bench for the eight-stream transfer controller.
`timescale 1ns/1ps
`include "xdma_map.svh"
module xdma_stream_ctrl_bench;
  import xdma_pkg::*;
  logic        clk, resetn, cfg_we, slow, err_a, err_b;
  logic [2:0]  cfg_stream, cfg_field;
  logic [31:0] cfg_wdata, a_addr, a_rdata, b_addr, b_wdata;
  logic [7:0]  periph_req, sw_trig, irq, stream_en, cur_buf;
  logic [23:0] flag_clr, flags;
  logic        a_req, a_ready, a_err, b_req, b_ready, b_err;
  logic [1:0]  a_size, b_size;
  xdma_state_t eng_state;
  int          miscompares, checks, seed;
  logic [31:0] src_w [0:15];
  xdma_stream_ctrl dut (.clk, .resetn, .cfg_we, .cfg_stream, .cfg_field,
    .cfg_wdata, .periph_req, .sw_trig, .flag_clr, .flags, .irq, .stream_en,
    .cur_buf, .eng_state, .a_req, .a_addr, .a_size, .a_ready, .a_rdata,
    .a_err, .b_req, .b_addr, .b_size, .b_wdata, .b_ready, .b_err);
  xdma_mem_model mm (.clk, .resetn, .slow, .err_a, .err_b, .a_req, .a_addr,
    .a_ready, .a_rdata, .a_err, .b_req, .b_addr, .b_size, .b_wdata, .b_ready,
    .b_err);
  // ********
  // Tasks
  // ********
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checks++;
    if (seen !== ex) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  function logic [31:0] ctl(input logic [1:0] dir, input logic circ, dbm,
                            sinc, input logic [1:0] bst, pr);
    return {14'h0, 3'h7, pr, bst, 2'h2, 2'h2, 1'b1, sinc, dbm, circ, dir, 1'b1};
  endfunction
  task cfg(input logic [2:0] s, f, input logic [31:0] d);
    @(posedge clk);
    cfg_we <= 1'b1; cfg_stream <= s; cfg_field <= f; cfg_wdata <= d;
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask
  task prog(input logic [2:0] s, input logic [31:0] sa, da, len, c);
    cfg(s, `XDMA_F_SRC, sa);
    cfg(s, `XDMA_F_DST, da);
    cfg(s, `XDMA_F_LEN, len);
    cfg(s, `XDMA_F_CTRL, c);
  endtask
  task tick; @(posedge clk); #1; endtask
  task wait_fl(input int s, b);
    int n;
    n = 0;
    while (flags[s*3+b] !== 1'b1 && n < 3000) begin tick; n++; end
    chk("flag", flags[s*3+b], 1'b1);
  endtask
  task clr(input int s);
    @(posedge clk); flag_clr[s*3 +: 3] <= 3'h7;
    @(posedge clk); flag_clr <= '0; #1;
  endtask
  task stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin clk = 0; forever #2 clk = ~clk; end
  initial begin #160000; miscompares++; stop_test; end
  // ********
  // Scenarios
  // ********
  initial begin
    int s, w, n;
    logic [31:0] v, r, c;
    seed = 32'hb7b1; resetn = 0; cfg_we = 0; cfg_stream = 0; cfg_field = 0;
    cfg_wdata = 0; periph_req = 0; sw_trig = 0; flag_clr = 0;
    slow = 0; err_a = 0; err_b = 0;
    repeat (10) @(posedge clk);
    #1 chk("rst", {flags, stream_en}, 0); chk("st", eng_state, XDMA_IDLE);
    @(posedge clk) resetn <= 1'b1;
    // Random memory copies: burst, length, priority, waits, item sizes
    for (int k = 0; k < 8; k++) begin
      v = $random(seed); r = $random(seed);
      s = v[2:0]; w = 1 + v[6:3]; slow <= v[7];
      for (int i = 0; i < w; i++) begin
        src_w[i] = $random(seed); mm.mem[i] = src_w[i];
        mm.mem[128+i] = ~src_w[i];
      end
      c = ctl(`XDMA_DIR_M2M, 0, 0, 1, r[1:0], r[3:2]);
      // Unused size code folds to word; first two runs force byte items
      c[`XDMA_C_SSZ] = (r[5:4] == 2'h3) ? 2'h2 : r[5:4];
      c[`XDMA_C_DSZ] = (r[7:6] == 2'h3) ? 2'h2 : r[7:6];
      if (k == 0) c[`XDMA_C_SSZ] = 2'h0;
      if (k == 1) c[`XDMA_C_DSZ] = 2'h0;
      prog(3'(s), 0, 32'h200, w*4, c);
      wait_fl(s, `XDMA_FL_TC);
      chk("ht", flags[s*3], 1'b1); chk("en", stream_en[s], 1'b0);
      tick; chk("irq", irq[s], 1'b1);
      for (int i = 0; i < w; i++) chk("dst", mm.mem[128+i], src_w[i]);
      clr(s); chk("clr", flags[s*3 +: 3], 0);
      tick; chk("irq0", irq[s], 1'b0);
    end
    slow <= 1'b0;
    // Three peripheral streams raised at once; tie goes to lower index
    prog(2, 32'h8, 32'h240, 4, ctl(`XDMA_DIR_P2M, 0, 0, 0, 0, 2'h1));
    prog(5, 32'h14, 32'h244, 4, ctl(`XDMA_DIR_P2M, 0, 0, 0, 0, 2'h3));
    prog(6, 32'h18, 32'h248, 4, ctl(`XDMA_DIR_P2M, 0, 0, 0, 0, 2'h3));
    repeat (20) tick;
    chk("noreq", stream_en & 8'h64, 8'h64);
    @(posedge clk) periph_req <= 8'h64;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      while (a_req !== 1'b1 && n < 200) begin tick; n++; end
      chk("order", a_addr, k == 0 ? 32'h14 : k == 1 ? 32'h18 : 32'h8);
      chk("asz", a_size, 2'h2);
      while (a_req === 1'b1) tick;
      while (b_req !== 1'b1) tick;
      chk("bsz", b_size, 2'h2);
    end
    periph_req <= 0;
    v = $random(seed); mm.mem[1] = v; mm.mem[8'h94] = ~v;
    prog(1, 32'h4, 32'h250, 4, ctl(`XDMA_DIR_P2M, 0, 0, 0, 0, 0));
    @(posedge clk) sw_trig <= 8'h02;
    @(posedge clk) sw_trig <= 8'h00;
    wait_fl(1, `XDMA_FL_TC);
    chk("swd", mm.mem[8'h94], v);
    // Circular peripheral stream stays enabled after completion
    v = $random(seed); mm.mem[3] = v; mm.mem[8'h98] = ~v;
    prog(3, 32'hc, 32'h260, 8, ctl(`XDMA_DIR_P2M, 1, 0, 0, 0, 0));
    @(posedge clk) periph_req <= 8'h08;
    wait_fl(3, `XDMA_FL_TC);
    periph_req <= 0;
    repeat (30) tick;
    chk("circ", stream_en[3], 1'b1); chk("cdat", mm.mem[8'h98], v);
    cfg(3, `XDMA_F_CTRL, 0);
    // Double buffer alternates destination between base and second buffer
    v = $random(seed); mm.mem[16] = v; mm.mem[8'hc0] = ~v; mm.mem[8'he0] = ~v;
    cfg(4, `XDMA_F_MEM1, 32'h380);
    prog(4, 32'h40, 32'h300, 4, ctl(`XDMA_DIR_P2M, 0, 1, 0, 0, 0));
    @(posedge clk) periph_req <= 8'h10;
    wait_fl(4, `XDMA_FL_TC);
    chk("buf1", cur_buf[4], 1'b1); chk("d0", mm.mem[8'hc0], v);
    clr(4);
    wait_fl(4, `XDMA_FL_TC);
    chk("buf0", cur_buf[4], 1'b0); chk("d1", mm.mem[8'he0], v);
    periph_req <= 0;
    repeat (30) tick;
    cfg(4, `XDMA_F_CTRL, 0);
    // Memory-to-peripheral double buffer swaps the source side
    v = $random(seed); r = $random(seed);
    mm.mem[24] = v; mm.mem[25] = r; mm.mem[8'ha8] = ~v;
    cfg(7, `XDMA_F_MEM1, 32'h64);
    prog(7, 32'h60, 32'h2a0, 4, ctl(`XDMA_DIR_M2P, 0, 1, 0, 0, 0));
    @(posedge clk) periph_req <= 8'h80;
    wait_fl(7, `XDMA_FL_TC);
    chk("m2p0", mm.mem[8'ha8], v);
    clr(7);
    wait_fl(7, `XDMA_FL_TC);
    chk("m2p1", mm.mem[8'ha8], r);
    periph_req <= 0;
    repeat (30) tick;
    cfg(7, `XDMA_F_CTRL, 0);
    // Read error aborts the stream
    @(posedge clk) err_a <= 1'b1;
    prog(0, 0, 32'h200, 16, ctl(`XDMA_DIR_M2M, 0, 0, 1, 0, 0));
    wait_fl(0, `XDMA_FL_TE);
    chk("teen", stream_en[0], 1'b0);
    tick; chk("teirq", irq[0], 1'b1);
    err_a <= 1'b0;
    // Write error aborts the stream as well
    clr(0);
    @(posedge clk) err_b <= 1'b1;
    prog(0, 0, 32'h200, 16, ctl(`XDMA_DIR_M2M, 0, 0, 1, 0, 0));
    wait_fl(0, `XDMA_FL_TE);
    chk("tewr", stream_en[0], 1'b0);
    err_b <= 1'b0;
    stop_test;
  end
endmodule // xdma_stream_ctrl_bench

// ==== dv/xdma_stream_ctrl_monitor.sv ====
// Port-level assertions for the stream transfer controller, with its bind.
`timescale 1ns/1ps
`include "xdma_map.svh"
module xdma_stream_ctrl_monitor
  import xdma_pkg::*;
#(
  parameter int NS = 8
) (
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire logic [NS*`XDMA_NFL-1:0] flag_clr,
  input wire logic [NS*`XDMA_NFL-1:0] flags,
  input wire logic [NS-1:0]           irq,
  input wire logic [NS-1:0]           stream_en,
  input xdma_pkg::xdma_state_t        eng_state,
  input wire logic                    a_req,
  input wire logic [31:0]             a_addr,
  input wire logic [1:0]              a_size,
  input wire logic                    a_ready,
  input wire logic                    a_err,
  input wire logic                    b_req,
  input wire logic [31:0]             b_addr,
  input wire logic [31:0]             b_wdata,
  input wire logic                    b_ready
);
  logic [NS-1:0] fl_any;
  logic [NS-1:0] te_any;
  always_comb begin
    for (int i = 0; i < NS; i++) begin
      fl_any[i] = |flags[i*`XDMA_NFL +: `XDMA_NFL];
      te_any[i] = flags[i*`XDMA_NFL+`XDMA_FL_TE];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence rd_wait; a_req && !a_ready; endsequence
  sequence rd_beat; a_req && a_ready; endsequence
  sequence rd_fail; a_req && a_ready && a_err; endsequence
  sequence wr_wait; b_req && !b_ready; endsequence
  a_rd_hold: assert property (
    rd_wait |=> a_req && $stable(a_addr) && $stable(a_size))
    else $error("read request moved before ready");
  a_wr_hold: assert property (
    wr_wait |=> b_req && $stable(b_addr) && $stable(b_wdata))
    else $error("write request moved before ready");
  a_rd_step: assert property (
    rd_beat ##1 a_req |-> a_addr == $past(a_addr) ||
      a_addr == $past(a_addr) + (32'h1 << a_size))
    else $error("burst read address step wrong");
  a_rd_state: assert property (
    a_req |-> eng_state == XDMA_RD)
    else $error("read request outside read state");
  a_wr_entry: assert property (
    $rose(b_req) |-> $past(eng_state) inside {XDMA_FETCH, XDMA_MERGE})
    else $error("write started without fetched data");
  a_done_idle: assert property (
    eng_state == XDMA_DONE |=> eng_state == XDMA_IDLE)
    else $error("engine did not return to idle");
  a_start_en: assert property (
    $rose(a_req) |-> $past(stream_en) != '0)
    else $error("service started with no enabled stream");
  a_irq_cause: assert property (
    (irq & ~fl_any) == '0)
    else $error("interrupt without a flag");
  a_flag_sticky: assert property (
    ($past(flags) & ~flags & ~$past(flag_clr)) == '0)
    else $error("flag dropped without clear");
  a_err_flag: assert property (
    rd_fail |-> ##[1:4] te_any != '0)
    else $error("bus error not flagged");
endmodule // xdma_stream_ctrl_monitor

bind xdma_stream_ctrl xdma_stream_ctrl_monitor #(.NS(NS)) u_mon (
  .clk, .resetn, .flag_clr, .flags, .irq, .stream_en, .eng_state,
  .a_req, .a_addr, .a_size, .a_ready, .a_err,
  .b_req, .b_addr, .b_wdata, .b_ready);

// ==== logic/xdma_fifo_mem.sv ====
// Shared storage for all per-stream FIFOs, registered read data.
`timescale 1ns/1ps
module xdma_fifo_mem #(
  parameter int W  = 32,
  parameter int AW = 7
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule // xdma_fifo_mem

// ==== logic/xdma_map.svh ====
// Constants of the stream transfer controller: field codes, bit positions.
`ifndef XDMA_MAP_SVH
`define XDMA_MAP_SVH
// ****************************************************************
// Configuration field selectors
// ****************************************************************
`define XDMA_F_CTRL   3'h0
`define XDMA_F_SRC    3'h1
`define XDMA_F_DST    3'h2
`define XDMA_F_MEM1   3'h3
`define XDMA_F_LEN    3'h4
// ****************************************************************
// Control word layout
// ****************************************************************
`define XDMA_C_EN     0
`define XDMA_C_DIR    2:1
`define XDMA_C_CIRC   3
`define XDMA_C_DBM    4
`define XDMA_C_SINC   5
`define XDMA_C_DINC   6
`define XDMA_C_SSZ    8:7
`define XDMA_C_DSZ    10:9
`define XDMA_C_BURST  12:11
`define XDMA_C_PRIO   14:13
`define XDMA_C_IE     17:15
`define XDMA_CTRL_W   18
`define XDMA_DIR_P2M  2'h0
`define XDMA_DIR_M2P  2'h1
`define XDMA_DIR_M2M  2'h2
// ****************************************************************
// Status flag positions
// ****************************************************************
`define XDMA_FL_HT    0
`define XDMA_FL_TC    1
`define XDMA_FL_TE    2
`define XDMA_NFL      3
`endif

// ==== logic/xdma_pkg.sv ====
// Types shared by the stream transfer controller.
package xdma_pkg;
  typedef enum logic [2:0] {
    XDMA_IDLE,
    XDMA_RD,
    XDMA_FETCH,
    XDMA_MERGE,
    XDMA_WR,
    XDMA_DONE
  } xdma_state_t;
endpackage

// ==== logic/xdma_stream_ctrl.sv ====
// Eight-stream transfer controller with a read master and a write master.
`timescale 1ns/1ps
`include "xdma_map.svh"
module xdma_stream_ctrl #(
  parameter int NS    = 8,
  parameter int DEPTH = 16,
  parameter int LW    = 16
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     cfg_we,
  input  wire logic [$clog2(NS)-1:0]    cfg_stream,
  input  wire logic [2:0]               cfg_field,
  input  wire logic [31:0]              cfg_wdata,
  input  wire logic [NS-1:0]            periph_req,
  input  wire logic [NS-1:0]            sw_trig,
  input  wire logic [NS*`XDMA_NFL-1:0]  flag_clr,
  output logic      [NS*`XDMA_NFL-1:0]  flags,
  output logic      [NS-1:0]            irq,
  output logic      [NS-1:0]            stream_en,
  output logic      [NS-1:0]            cur_buf,
  output xdma_pkg::xdma_state_t         eng_state,
  output logic                          a_req,
  output logic      [31:0]              a_addr,
  output logic      [1:0]               a_size,
  input  wire logic                     a_ready,
  input  wire logic [31:0]              a_rdata,
  input  wire logic                     a_err,
  output logic                          b_req,
  output logic      [31:0]              b_addr,
  output logic      [1:0]               b_size,
  output logic      [31:0]              b_wdata,
  input  wire logic                     b_ready,
  input  wire logic                     b_err
);
  import xdma_pkg::*;
  localparam int SW = $clog2(NS);
  localparam int PW = $clog2(DEPTH);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [`XDMA_CTRL_W-1:0] ctrl_reg [NS];
  logic [31:0]  src_base_reg [NS], dst_base_reg [NS], mem1_reg [NS];
  logic [31:0]  src_cur_reg [NS], dst_cur_reg [NS];
  logic [LW-1:0] len_reg [NS], rem_reg [NS];
  logic [NS-1:0] buf_reg;
  logic [PW:0]   wp_reg [NS], rp_reg [NS];
  logic [NS-1:0] req_s1_reg, req_s2_reg, swp_reg;
  logic [NS*`XDMA_NFL-1:0] flags_reg;
  logic [NS-1:0] irq_reg;
  xdma_state_t   st_reg;
  logic [SW-1:0] cur_reg;
  logic [7:0]    svc_rd_reg, svc_wr_reg;
  logic [63:0]   pk_reg;
  logic [3:0]    pk_cnt_reg;
  logic          err_reg;
  logic [31:0]   mem_rdata;

  // Fields of the stream being served
  logic [`XDMA_CTRL_W-1:0] cc;
  logic [3:0] sb, db;
  logic       rd_ok, wr_ok, pop, served_end;
  logic [LW-1:0] rem_new;
  assign cc      = ctrl_reg[cur_reg];
  assign sb      = 4'h1 << cc[`XDMA_C_SSZ];
  assign db      = 4'h1 << cc[`XDMA_C_DSZ];
  assign rd_ok   = (st_reg == XDMA_RD) && a_ready && !a_err;
  assign wr_ok   = (st_reg == XDMA_WR) && b_ready && !b_err;
  assign pop     = (st_reg == XDMA_FETCH) && (pk_cnt_reg < db);
  assign rem_new = rem_reg[cur_reg] - LW'(db);
  assign served_end = (st_reg == XDMA_DONE) && !err_reg
                    && (rem_reg[cur_reg] == '0);

  // ****************************************************************
  // Request capture and arbitration
  // ****************************************************************
  logic [NS-1:0] elig;
  logic          win_v;
  logic [SW-1:0] win_i;
  logic [1:0]    win_p;
  logic [7:0]    svc_full, win_svc;
  logic [3:0]    wsb, wdb, unit;

  for (genvar i = 0; i < NS; i++) begin : g_req
    // Request lines come from other logic clocked elsewhere
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        req_s1_reg[i] <= 1'b0;
        req_s2_reg[i] <= 1'b0;
      end else begin
        req_s1_reg[i] <= periph_req[i];
        req_s2_reg[i] <= req_s1_reg[i];
      end
    end
    // A trigger arriving as the stream is taken stays pending
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        swp_reg[i] <= 1'b0;
      end else begin
        swp_reg[i] <= (swp_reg[i] && !(st_reg == XDMA_IDLE && win_v
                      && win_i == SW'(i))) || sw_trig[i];
      end
    end
    assign elig[i] = ctrl_reg[i][`XDMA_C_EN] && rem_reg[i] != '0
      && (ctrl_reg[i][`XDMA_C_DIR] == `XDMA_DIR_M2M
          || req_s2_reg[i] || swp_reg[i]);
  end

  always_comb begin
    win_v = 1'b0;
    win_i = '0;
    win_p = 2'h0;
    // Walk downward so an equal priority lets the lower index take over
    for (int i = NS - 1; i >= 0; i--) begin
      if (elig[i] && (!win_v || ctrl_reg[i][`XDMA_C_PRIO] >= win_p)) begin
        win_v = 1'b1;
        win_i = SW'(i);
        win_p = ctrl_reg[i][`XDMA_C_PRIO];
      end
    end
    wsb      = 4'h1 << ctrl_reg[win_i][`XDMA_C_SSZ];
    wdb      = 4'h1 << ctrl_reg[win_i][`XDMA_C_DSZ];
    unit     = (wsb > wdb) ? wsb : wdb;
    svc_full = {4'h0, unit} * ({6'h0, ctrl_reg[win_i][`XDMA_C_BURST]}
               + 8'h1);
    win_svc  = (LW'(svc_full) > rem_reg[win_i]) ? 8'(rem_reg[win_i])
                                                : svc_full;
  end

  // ****************************************************************
  // Transfer engine
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg     <= XDMA_IDLE;
      cur_reg    <= '0;
      svc_rd_reg <= 8'h0;
      svc_wr_reg <= 8'h0;
      pk_reg     <= 64'h0;
      pk_cnt_reg <= 4'h0;
      err_reg    <= 1'b0;
      a_req      <= 1'b0;
      a_addr     <= 32'h0;
      a_size     <= 2'h0;
      b_req      <= 1'b0;
      b_addr     <= 32'h0;
      b_size     <= 2'h0;
      b_wdata    <= 32'h0;
    end else begin
      case (st_reg)
        XDMA_IDLE: begin
          err_reg    <= 1'b0;
          pk_reg     <= 64'h0;
          pk_cnt_reg <= 4'h0;
          if (win_v) begin
            cur_reg    <= win_i;
            svc_rd_reg <= win_svc;
            svc_wr_reg <= win_svc;
            a_req      <= 1'b1;
            a_addr     <= src_cur_reg[win_i];
            a_size     <= ctrl_reg[win_i][`XDMA_C_SSZ];
            st_reg     <= XDMA_RD;
          end
        end
        XDMA_RD: begin
          if (a_ready && a_err) begin
            a_req   <= 1'b0;
            err_reg <= 1'b1;
            st_reg  <= XDMA_DONE;
          end else if (rd_ok) begin
            svc_rd_reg <= svc_rd_reg - 8'(sb);
            a_addr     <= a_addr + (cc[`XDMA_C_SINC] ? 32'(sb) : 32'h0);
            // Beats stay back to back until the burst is read
            if (svc_rd_reg == 8'(sb)) begin
              a_req  <= 1'b0;
              st_reg <= XDMA_FETCH;
            end
          end
        end
        XDMA_FETCH: begin
          if (pk_cnt_reg >= db) begin
            b_req   <= 1'b1;
            b_addr  <= dst_cur_reg[cur_reg];
            b_size  <= cc[`XDMA_C_DSZ];
            b_wdata <= pk_reg[31:0];
            st_reg  <= XDMA_WR;
          end else begin
            st_reg <= XDMA_MERGE;
          end
        end
        XDMA_MERGE: begin
          // Append one source item above the bytes still held
          pk_reg <= pk_reg | ({32'h0, mem_rdata & ~(32'hffffffff << {sb, 3'h0})}
                    << {pk_cnt_reg, 3'h0});
          pk_cnt_reg <= pk_cnt_reg + sb;
          st_reg     <= XDMA_FETCH;
        end
        XDMA_WR: begin
          if (b_ready && b_err) begin
            b_req   <= 1'b0;
            err_reg <= 1'b1;
            st_reg  <= XDMA_DONE;
          end else if (wr_ok) begin
            b_req      <= 1'b0;
            pk_reg     <= pk_reg >> {db, 3'h0};
            pk_cnt_reg <= pk_cnt_reg - db;
            svc_wr_reg <= svc_wr_reg - 8'(db);
            st_reg     <= (svc_wr_reg == 8'(db)) ? XDMA_DONE : XDMA_FETCH;
          end
        end
        default: begin
          st_reg <= XDMA_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Per-stream FIFO pointers and storage
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NS; i++) begin
        wp_reg[i] <= '0;
        rp_reg[i] <= '0;
      end
    end else begin
      if (rd_ok) begin
        wp_reg[cur_reg] <= wp_reg[cur_reg] + 1'b1;
      end
      if (pop) begin
        rp_reg[cur_reg] <= rp_reg[cur_reg] + 1'b1;
      end
      // An error drops whatever the stream still holds
      if (st_reg == XDMA_DONE && err_reg) begin
        rp_reg[cur_reg] <= wp_reg[cur_reg];
      end
    end
  end

  xdma_fifo_mem #(.W(32), .AW(SW + PW)) u_fifo (
    .clk   (clk),
    .we    (rd_ok),
    .waddr ({cur_reg, wp_reg[cur_reg][PW-1:0]}),
    .wdata (a_rdata),
    .raddr ({cur_reg, rp_reg[cur_reg][PW-1:0]}),
    .rdata (mem_rdata)
  );

  // ****************************************************************
  // Stream configuration and progress
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NS; i++) begin
        ctrl_reg[i]     <= '0;
        src_base_reg[i] <= 32'h0;
        dst_base_reg[i] <= 32'h0;
        mem1_reg[i]     <= 32'h0;
        src_cur_reg[i]  <= 32'h0;
        dst_cur_reg[i]  <= 32'h0;
        len_reg[i]      <= '0;
        rem_reg[i]      <= '0;
      end
      buf_reg <= '0;
    end else begin
      if (cfg_we) begin
        if (cfg_field == `XDMA_F_CTRL) begin
          ctrl_reg[cfg_stream] <= cfg_wdata[`XDMA_CTRL_W-1:0];
          if (cfg_wdata[`XDMA_C_EN]) begin
            src_cur_reg[cfg_stream] <= src_base_reg[cfg_stream];
            dst_cur_reg[cfg_stream] <= dst_base_reg[cfg_stream];
            rem_reg[cfg_stream]     <= len_reg[cfg_stream];
            buf_reg[cfg_stream]     <= 1'b0;
          end
        end else if (cfg_field == `XDMA_F_SRC) begin
          src_base_reg[cfg_stream] <= cfg_wdata;
        end else if (cfg_field == `XDMA_F_DST) begin
          dst_base_reg[cfg_stream] <= cfg_wdata;
        end else if (cfg_field == `XDMA_F_MEM1) begin
          mem1_reg[cfg_stream] <= cfg_wdata;
        end else if (cfg_field == `XDMA_F_LEN) begin
          len_reg[cfg_stream] <= cfg_wdata[LW-1:0];
        end
      end
      if (rd_ok && cc[`XDMA_C_SINC]) begin
        src_cur_reg[cur_reg] <= src_cur_reg[cur_reg] + 32'(sb);
      end
      if (wr_ok) begin
        rem_reg[cur_reg] <= rem_new;
        if (cc[`XDMA_C_DINC]) begin
          dst_cur_reg[cur_reg] <= dst_cur_reg[cur_reg] + 32'(db);
        end
      end
      if (st_reg == XDMA_DONE && err_reg) begin
        ctrl_reg[cur_reg][`XDMA_C_EN] <= 1'b0;
      end else if (served_end) begin
        rem_reg[cur_reg]     <= len_reg[cur_reg];
        src_cur_reg[cur_reg] <= src_base_reg[cur_reg];
        dst_cur_reg[cur_reg] <= dst_base_reg[cur_reg];
        if (cc[`XDMA_C_DBM]) begin
          // Source alternates for M2P, destination for P2M and M2M; the peripheral side stays put
          buf_reg[cur_reg] <= !buf_reg[cur_reg];
          if (!buf_reg[cur_reg]) begin
            if (cc[`XDMA_C_DIR] == `XDMA_DIR_M2P) begin
              src_cur_reg[cur_reg] <= mem1_reg[cur_reg];
            end else begin
              dst_cur_reg[cur_reg] <= mem1_reg[cur_reg];
            end
          end
        end else if (!cc[`XDMA_C_CIRC]) begin
          ctrl_reg[cur_reg][`XDMA_C_EN] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Status flags and interrupt requests
  // ****************************************************************
  for (genvar i = 0; i < NS; i++) begin : g_flag
    logic [`XDMA_NFL-1:0] set;
    logic [`XDMA_NFL-1:0] nxt;
    logic                 mine;
    assign mine = (cur_reg == SW'(i));
    assign set[`XDMA_FL_HT] = mine && wr_ok
      && rem_reg[i] > (len_reg[i] >> 1) && rem_new <= (len_reg[i] >> 1);
    assign set[`XDMA_FL_TC] = mine && served_end;
    assign set[`XDMA_FL_TE] = mine && st_reg == XDMA_DONE && err_reg;
    // Set beats a clear in the same cycle
    assign nxt = (flags_reg[i*`XDMA_NFL +: `XDMA_NFL]
                 & ~flag_clr[i*`XDMA_NFL +: `XDMA_NFL]) | set;
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        flags_reg[i*`XDMA_NFL +: `XDMA_NFL] <= '0;
        irq_reg[i] <= 1'b0;
      end else begin
        flags_reg[i*`XDMA_NFL +: `XDMA_NFL] <= nxt;
        irq_reg[i] <= |(nxt & ctrl_reg[i][`XDMA_C_IE]);
      end
    end
    assign stream_en[i] = ctrl_reg[i][`XDMA_C_EN];
  end

  assign flags     = flags_reg;
  assign irq       = irq_reg;
  assign cur_buf   = buf_reg;
  assign eng_state = st_reg;
endmodule // xdma_stream_ctrl
